// ==== rtl/dwtm_sequencer.v ====
// Display word timing sequencer and instruction mode decoder
module dwtm_sequencer
#(
   parameter PC_WIDTH = 16
)
(
   // System
   input  wire        clk,
   input  wire        reset,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Memory fetch side
   input  wire        fetchWordValid,
   input  wire [15:0] busData,
   input  wire        charSecondPending,
   output reg         fetchRequest_r,
   output reg         masterSync_r,
   // Phases and operation strobes
   output reg         phaseCaptureWord_r,
   output reg         phaseLoadRegs_r,
   output reg         phaseAdvanceCounter_r,
   output reg         phaseDispatch_r,
   output reg  [15:0] operationStrobe_r,
   output reg         operationStart_r,
   output reg         hung_r
);
`include "dwtm_regs.vh"

   // Pin synchronisers
   reg        validMeta_r, validSync_r, validPrev_r;
   reg        charMeta_r, charSync_r;
   reg [15:0] dataMeta_r, dataSync_r;

   // Sequencer state
   wire       halfRateClock;
   wire       gatedSequencerClock;
   reg        startPending_r;
   reg        restartStart_r;
   reg        sequenceArmed_r;
   reg        sequenceRunning_r;
   reg [3:0]  phaseCounter_r;
   reg        secondCharRestart_r;
   reg        charHalf_r;

   // Decode state
   reg [15:0] capturedWord_r;
   reg [2:0]  controlMode_r;
   reg [3:0]  dataMode_r;
   reg        controlWordFlag_r;
   reg        jumpTargetPending_r;
   reg [PC_WIDTH-1:0] displayProgramCounter_r;
   reg        restartCycle_r;

   // Software controls
   reg        fetchInhibit_r;
   wire       apbWrite;
   wire       apbRead;
   wire [3:0] selectedModeCode;
   wire [15:0] decodedStrobes;
   wire       fetchStart;
   wire       phaseTick;
   wire [2:0] phaseIndex;

   // Is a strobe code one that hangs the device
   function isHangCode;
      input [3:0] code;
   begin
      isHangCode = (code == `DWTM_M_SPARE1) || (code == `DWTM_M_SPARE2) ||
                   (code == `DWTM_M_SPARE3) || (code == `DWTM_M_DATA_SPARE);
   end
   endfunction

   dwtm_clock_gen u_clock
   (
      .clk                   (clk),
      .reset                 (reset),
      .halfRateClock_r       (halfRateClock),
      .gatedSequencerClock_r (gatedSequencerClock)
   );

   dwtm_mode_decode u_decode
   (
      .selectedModeCode      (selectedModeCode),
      .operationStrobes      (decodedStrobes)
   );

   // Two-flop synchronisers for pins
   always @(posedge clk)
   begin
      if (reset)
      begin
         validMeta_r <= 1'b0;
         validSync_r <= 1'b0;
         validPrev_r <= 1'b0;
         charMeta_r  <= 1'b0;
         charSync_r  <= 1'b0;
         dataMeta_r  <= 16'h0000;
         dataSync_r  <= 16'h0000;
      end
      else
      begin
         validMeta_r <= fetchWordValid;
         validSync_r <= validMeta_r;
         validPrev_r <= validSync_r;
         charMeta_r  <= charSecondPending;
         charSync_r  <= charMeta_r;
         dataMeta_r  <= busData;
         dataSync_r  <= dataMeta_r;
      end
   end

   // Acknowledge only counts while a fetch is outstanding
   assign fetchStart = validSync_r & ~validPrev_r & masterSync_r;
   assign phaseTick  = gatedSequencerClock & sequenceRunning_r;
   assign phaseIndex = phaseCounter_r[2:0];

   // Mode multiplexer: control register for instructions, else data
   assign selectedModeCode = controlWordFlag_r ? {1'b1, controlMode_r} : dataMode_r;

   // Start gating, arming and running flags
   always @(posedge clk)
   begin
      if (reset)
      begin
         startPending_r    <= 1'b0;
         restartStart_r    <= 1'b0;
         sequenceArmed_r   <= 1'b0;
         sequenceRunning_r <= 1'b0;
         phaseCounter_r    <= 4'h0;
      end
      else if (phaseTick && phaseIndex == `DWTM_PH_DISPATCH)
      begin
         sequenceArmed_r   <= 1'b0;
         sequenceRunning_r <= 1'b0;
         startPending_r    <= 1'b0;
      end
      else
      begin
         // Start request held until the gated pulses take it
         if (!startPending_r && !sequenceRunning_r && !hung_r && (fetchStart || secondCharRestart_r))
         begin
            startPending_r <= 1'b1;
            restartStart_r <= secondCharRestart_r & ~fetchStart;
         end
         if (gatedSequencerClock && startPending_r && !sequenceRunning_r)
         begin
            if (!sequenceArmed_r)
            begin
               // First pulse clears or presets, then arms
               phaseCounter_r  <= restartStart_r ? `DWTM_PH_RESTART : 4'h0;
               sequenceArmed_r <= 1'b1;
            end
            else
               sequenceRunning_r <= 1'b1;
         end
         else if (phaseTick)
            phaseCounter_r <= phaseCounter_r + 4'h1;
      end
   end

   // One-hot phase pulses from the counter
   always @(posedge clk)
   begin
      if (reset)
      begin
         phaseCaptureWord_r    <= 1'b0;
         phaseLoadRegs_r       <= 1'b0;
         phaseAdvanceCounter_r <= 1'b0;
         phaseDispatch_r       <= 1'b0;
      end
      else
      begin
         phaseCaptureWord_r    <= phaseTick && phaseIndex == `DWTM_PH_CAPTURE;
         phaseLoadRegs_r       <= phaseTick && phaseIndex == `DWTM_PH_LOAD;
         phaseAdvanceCounter_r <= phaseTick && phaseIndex == `DWTM_PH_ADVANCE;
         phaseDispatch_r       <= phaseTick && phaseIndex == `DWTM_PH_DISPATCH;
      end
   end

   // Word capture and mode registers
   always @(posedge clk)
   begin
      if (reset)
      begin
         capturedWord_r      <= 16'h0000;
         controlMode_r       <= `DWTM_MODE_RESET;
         dataMode_r          <= `DWTM_DMODE_RESET;
         controlWordFlag_r   <= 1'b0;
         jumpTargetPending_r <= 1'b0;
         charHalf_r          <= 1'b0;
      end
      else
      begin
         if (phaseCaptureWord_r)
         begin
            capturedWord_r <= dataSync_r;
            if (!jumpTargetPending_r)
            begin
               if (dataSync_r[`DWTM_BIT_INSTR])
               begin
                  charHalf_r        <= 1'b0;
                  controlWordFlag_r <= 1'b1;
                  if (dataSync_r[`DWTM_BIT_CONTROL])
                     controlMode_r <= dataSync_r[`DWTM_CODE_HI:`DWTM_CODE_LO];
                  else
                  begin
                     dataMode_r    <= dataSync_r[`DWTM_BIT_CONTROL:`DWTM_CODE_LO];
                     controlMode_r <= `DWTM_MODE_RESET;
                  end
               end
               else if (dataMode_r != `DWTM_M_CHARACTER || controlWordFlag_r)
                  controlWordFlag_r <= 1'b0;
               else
                  controlWordFlag_r <= 1'b0;
            end
         end
         // Jump word arms capture of the target on the next fetch
         if (phaseDispatch_r && !restartCycle_r)
            jumpTargetPending_r <= !jumpTargetPending_r && controlWordFlag_r &&
                                   selectedModeCode == `DWTM_M_JUMP;
         // Each half of a character word toggles the half flag
         if (phaseDispatch_r && selectedModeCode == `DWTM_M_CHARACTER && !controlWordFlag_r)
            charHalf_r <= ~charHalf_r;
      end
   end

   // Restart request, program counter, fetch and dispatch
   always @(posedge clk)
   begin
      if (reset)
      begin
         secondCharRestart_r     <= 1'b0;
         restartCycle_r          <= 1'b0;
         displayProgramCounter_r <= {PC_WIDTH{1'b0}};
         fetchRequest_r          <= 1'b0;
         masterSync_r            <= 1'b0;
         operationStrobe_r       <= 16'h0000;
         operationStart_r        <= 1'b0;
         hung_r                  <= 1'b0;
      end
      else
      begin
         operationStart_r  <= 1'b0;
         operationStrobe_r <= 16'h0000;
         secondCharRestart_r <= 1'b0;
         if (startPending_r && !sequenceArmed_r)
            restartCycle_r <= restartStart_r;
         // Load phase ends the fetch
         if (phaseLoadRegs_r)
         begin
            fetchRequest_r <= 1'b0;
            masterSync_r   <= 1'b0;
         end
         // Program counter advance or jump load
         if (phaseAdvanceCounter_r && !restartCycle_r)
         begin
            if (jumpTargetPending_r)
               displayProgramCounter_r <= capturedWord_r[PC_WIDTH-1:0];
            else
               displayProgramCounter_r <= displayProgramCounter_r + {{(PC_WIDTH-1){1'b0}}, 1'b1};
         end
         // Dispatch: hang, draw, or fetch next
         if (phaseDispatch_r)
         begin
            // Spare codes still show their strobe, and hang on the same edge
            if (!jumpTargetPending_r)
               operationStrobe_r <= decodedStrobes;
            if (!jumpTargetPending_r && isHangCode(selectedModeCode))
               hung_r <= 1'b1;
            else
            begin
               if (!controlWordFlag_r && !jumpTargetPending_r)
               begin
                  operationStart_r <= 1'b1;
                  // Second packed character pending after the first
                  if (selectedModeCode == `DWTM_M_CHARACTER && !charHalf_r && charSync_r)
                     secondCharRestart_r <= 1'b1;
               end
               else if (!fetchInhibit_r)
               begin
                  fetchRequest_r <= 1'b1;
                  masterSync_r   <= 1'b1;
               end
            end
         end
         if (apbWrite && paddr == `DWTM_ADDR_CTRL)
         begin
            if (pwdata[`DWTM_CTRL_START] && !hung_r)
            begin
               displayProgramCounter_r <= pwdata[PC_WIDTH+15:16];
               fetchRequest_r <= 1'b1;
               masterSync_r   <= 1'b1;
            end
            if (pwdata[`DWTM_CTRL_RESUME])
            begin
               fetchRequest_r <= 1'b1;
               masterSync_r   <= 1'b1;
            end
         end
      end
   end

   // APB slave, one wait-free access phase
   assign apbWrite = psel & penable & pwrite & pready;
   assign apbRead  = psel & ~penable & ~pwrite;

   always @(posedge clk)
   begin
      if (reset)
      begin
         fetchInhibit_r <= 1'b0;
         prdata         <= 32'h00000000;
         pready         <= 1'b0;
         pslverr        <= 1'b0;
      end
      else
      begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         if (apbWrite && paddr == `DWTM_ADDR_CTRL)
            fetchInhibit_r <= pwdata[`DWTM_CTRL_INHIBIT];
         if (psel && !penable)
         begin
            prdata <= 32'h00000000;
            case (paddr)
               `DWTM_ADDR_CTRL:    prdata <= {31'h00000000, fetchInhibit_r};
               `DWTM_ADDR_STATUS:  prdata <= {15'h0000, hung_r, jumpTargetPending_r, controlWordFlag_r,
                                              charHalf_r, controlMode_r, dataMode_r, phaseCounter_r,
                                              sequenceRunning_r, sequenceArmed_r};
               `DWTM_ADDR_WORD:    prdata <= {16'h0000, capturedWord_r};
               `DWTM_ADDR_PC:      prdata <= {{(32-PC_WIDTH){1'b0}}, displayProgramCounter_r};
               `DWTM_ADDR_STROBES: prdata <= {16'h0000, decodedStrobes};
               default:            pslverr <= apbRead | (psel & ~penable);
            endcase
         end
      end
   end
endmodule // dwtm_sequencer

// ==== rtl/dwtm_regs.vh ====
// Constants of the display word timing and mode decoder
`ifndef DWTM_REGS_VH
`define DWTM_REGS_VH
// APB register byte addresses
`define DWTM_ADDR_CTRL      8'h00
`define DWTM_ADDR_STATUS    8'h04
`define DWTM_ADDR_WORD      8'h08
`define DWTM_ADDR_PC        8'h0c
`define DWTM_ADDR_STROBES   8'h10
// Control register fields
`define DWTM_CTRL_INHIBIT   0
`define DWTM_CTRL_START     1
`define DWTM_CTRL_RESUME    2
// Word fields
`define DWTM_BIT_INSTR      15
`define DWTM_BIT_CONTROL    14
`define DWTM_CODE_HI        13
`define DWTM_CODE_LO        11
// Phase counter values
`define DWTM_PH_CAPTURE     3'h0
`define DWTM_PH_LOAD        3'h1
`define DWTM_PH_ADVANCE     3'h2
`define DWTM_PH_DISPATCH    3'h3
`define DWTM_PH_RESTART     4'h2
// Selected mode codes
`define DWTM_M_GRAPHIC      4'h8
`define DWTM_M_SPARE1       4'h9
`define DWTM_M_SPARE2       4'ha
`define DWTM_M_SPARE3       4'hb
`define DWTM_M_JUMP         4'hc
`define DWTM_M_NOP          4'hd
`define DWTM_M_STATUS_A     4'he
`define DWTM_M_STATUS_B     4'hf
`define DWTM_M_CHARACTER    4'h0
`define DWTM_M_DATA_SPARE   4'h7
// Reset values
`define DWTM_MODE_RESET     3'h0
`define DWTM_DMODE_RESET    4'h0
`endif

// ==== rtl/dwtm_clock_gen.v ====
// Sequencer clock generator: divide by two, by four, and AND
module dwtm_clock_gen
(
   // System
   input  wire clk,
   input  wire reset,
   // Derived clocks as enables
   output reg  halfRateClock_r,
   output reg  gatedSequencerClock_r
);
   reg quarterRateClock_r;

   // Two dividers and the AND gate
   always @(posedge clk)
   begin
      if (reset)
      begin
         halfRateClock_r       <= 1'b0;
         quarterRateClock_r    <= 1'b0;
         gatedSequencerClock_r <= 1'b0;
      end
      else
      begin
         halfRateClock_r       <= ~halfRateClock_r;
         if (halfRateClock_r)
            quarterRateClock_r <= ~quarterRateClock_r;
         gatedSequencerClock_r <= (~halfRateClock_r) & (halfRateClock_r ^ quarterRateClock_r);
      end
   end
endmodule // dwtm_clock_gen

// ==== rtl/dwtm_mode_decode.v ====
// Selected mode code to one-hot operation strobes
module dwtm_mode_decode
(
   // Mode code
   input  wire [3:0]  selectedModeCode,
   // One-hot strobes
   output wire [15:0] operationStrobes
);
   // Four to sixteen decode, exactly one active
   assign operationStrobes = 16'h0001 << selectedModeCode;
endmodule // dwtm_mode_decode

// ==== dv/dwtm_sequencer_properties.sv ====
// Checker of phase order, strobes and bus answers of the sequencer
module dwtm_sequencer_properties
(
   // System
   input logic        clk,
   input logic        reset,
   // Register bus
   input logic        psel,
   input logic        penable,
   input logic        pready,
   input logic        pslverr,
   // Fetch side
   input logic        fetchRequest_r,
   input logic        masterSync_r,
   // Phases and strobes
   input logic        phaseCaptureWord_r,
   input logic        phaseLoadRegs_r,
   input logic        phaseAdvanceCounter_r,
   input logic        phaseDispatch_r,
   input logic [15:0] operationStrobe_r,
   input logic        hung_r
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // Phase spacing and exclusivity
   a_load_follows_capture: assert property (phaseCaptureWord_r |-> ##4 phaseLoadRegs_r)
      else $error("load phase missing after capture");
   a_advance_follows_load: assert property (phaseLoadRegs_r |-> ##4 phaseAdvanceCounter_r)
      else $error("advance phase missing after load");
   a_dispatch_follows_adv: assert property (phaseAdvanceCounter_r |-> ##4 phaseDispatch_r)
      else $error("dispatch phase missing after advance");
   a_phases_one_hot: assert property ($onehot0({phaseCaptureWord_r, phaseLoadRegs_r,
      phaseAdvanceCounter_r, phaseDispatch_r}))
      else $error("two phases at once");
   a_quiet_after_dispatch: assert property (phaseDispatch_r |=> !(phaseCaptureWord_r || phaseLoadRegs_r ||
      phaseAdvanceCounter_r || phaseDispatch_r) [*3])
      else $error("phase right after dispatch");
   // Strobes and fetch release; a jump target word dispatches with no strobe
   a_dispatch_one_strobe: assert property (phaseDispatch_r ##1 operationStrobe_r != 16'h0
      |-> $onehot(operationStrobe_r))
      else $error("dispatch without single strobe");
   a_strobe_needs_dispatch: assert property (operationStrobe_r != 16'h0 |-> $past(phaseDispatch_r))
      else $error("strobe without dispatch");
   a_load_releases_bus: assert property (phaseLoadRegs_r |=> !masterSync_r && !fetchRequest_r)
      else $error("fetch still held after load");
   a_spare_hangs: assert property (operationStrobe_r[7] || operationStrobe_r[9] ||
      operationStrobe_r[10] || operationStrobe_r[11] |-> hung_r)
      else $error("spare code did not hang");
   a_hung_holds: assert property (hung_r |=> hung_r && !phaseCaptureWord_r)
      else $error("hung state left");
   a_apb_answer: assert property (psel && !penable |=> pready && !pslverr || pready && pslverr)
      else $error("no answer after setup");
   a_reset_quiet: assert property (disable iff (1'b0) reset |=> !fetchRequest_r && !masterSync_r &&
      !hung_r && !phaseDispatch_r)
      else $error("outputs active after reset");
   // Main scenarios
   c_capture: cover property (phaseCaptureWord_r);
   c_jump: cover property (operationStrobe_r[12]);
   c_restart: cover property (phaseAdvanceCounter_r && !$past(phaseLoadRegs_r, 4));
   c_hung: cover property ($rose(hung_r));
endmodule // dwtm_sequencer_properties

bind dwtm_sequencer dwtm_sequencer_properties dwtm_sequencer_properties_i
(
   .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
   .fetchRequest_r(fetchRequest_r), .masterSync_r(masterSync_r), .phaseCaptureWord_r(phaseCaptureWord_r),
   .phaseLoadRegs_r(phaseLoadRegs_r), .phaseAdvanceCounter_r(phaseAdvanceCounter_r),
   .phaseDispatch_r(phaseDispatch_r), .operationStrobe_r(operationStrobe_r), .hung_r(hung_r)
);

// ==== dv/dwtm_mem_model.sv ====
// Memory partner that answers display program fetches
module dwtm_mem_model
(
   // System
   input  logic        clk,
   input  logic        reset,
   // Fetch request and answer
   input  logic        masterSync,
   input  logic        slowAnswer,
   input  logic [15:0] memWord,
   output logic        fetchWordValid,
   output logic [15:0] busData
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] waitCnt;
   // Answer after a short or long wait, hold until sync ends
   always @(posedge clk)
   begin
      if (reset)
      begin
         fetchWordValid <= 1'b0;
         busData        <= 16'hffff;
         waitCnt        <= 4'h0;
      end
      else if (!masterSync)
      begin
         if (fetchWordValid)
            busData <= ~busData; // Released lines show no stale word
         fetchWordValid <= 1'b0;
         waitCnt        <= 4'h0;
      end
      else if (!fetchWordValid)
      begin
         waitCnt <= waitCnt + 4'h1;
         if (waitCnt == (slowAnswer ? 4'hb : 4'h3))
         begin
            fetchWordValid <= 1'b1;
            busData        <= memWord;
         end
      end
   end
endmodule // dwtm_mem_model

// ==== dv/dwtm_sequencer_tb.sv ====
// Self-checking bench of the display word sequencer
`include "dwtm_regs.vh"
`define CHK(act, exp) begin testsRun++; if ((act) !== (exp)) begin errors++; $display("BAD t=%0t got %h exp %h", $time, act, exp); end end
module dwtm_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, reset, psel, penable, pwrite, slowAnswer, charSecondPending;
   logic        pready, pslverr, fetchWordValid, fetchRequest_r, masterSync_r, hung_r, operationStart_r;
   logic        phaseCaptureWord_r, phaseLoadRegs_r, phaseAdvanceCounter_r, phaseDispatch_r;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] busData, memWord, operationStrobe_r;
   logic        e;
   int          errors, testsRun;

   dwtm_sequencer dwtm_sequencer_i (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fetchWordValid(fetchWordValid), .busData(busData), .charSecondPending(charSecondPending),
      .fetchRequest_r(fetchRequest_r), .masterSync_r(masterSync_r), .phaseCaptureWord_r(phaseCaptureWord_r),
      .phaseLoadRegs_r(phaseLoadRegs_r), .phaseAdvanceCounter_r(phaseAdvanceCounter_r),
      .phaseDispatch_r(phaseDispatch_r), .operationStrobe_r(operationStrobe_r), .operationStart_r(operationStart_r),
      .hung_r(hung_r));
   dwtm_mem_model dwtm_mem_model_i (.clk(clk), .reset(reset), .masterSync(masterSync_r),
      .slowAnswer(slowAnswer), .memWord(memWord), .fetchWordValid(fetchWordValid), .busData(busData));

   // Counts and verdict
   task print_verdict;
   begin
      $display("Comparisons %0d mismatches %0d", testsRun, errors);
      if (errors == 0 && testsRun > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   end
   endtask

   // One register bus transfer, waits for pready
   task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
   begin
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (!pready && n < 20);
      if (n >= 20)
      begin
         `CHK(1'b0, 1'b1);
         print_verdict;
      end
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   end
   endtask

   // Watch one word pass through the phases, then queue the next word
   task run_word(input int idx, input logic [15:0] nxt, input bit rst);
      int n, tc, tl, ta, td;
   begin
      tc = 0;
      tl = 0;
      ta = 0;
      td = 0;
      for (n = 1; n < 300 && td == 0; n++)
      begin
         @(posedge clk);
         if (phaseCaptureWord_r) tc = n;
         if (phaseLoadRegs_r) tl = n;
         if (phaseAdvanceCounter_r) ta = n;
         if (phaseDispatch_r) td = n;
      end
      if (td == 0)
      begin
         `CHK(1'b0, 1'b1);
         print_verdict;
      end
      @(posedge clk);
      memWord <= nxt;
      if (idx >= 0) `CHK(operationStrobe_r, 16'h1 << idx);
      `CHK(operationStart_r, idx >= 0 && idx < 7);
      if (rst) `CHK(tc + tl, 0);
      if (!rst) `CHK(tl - tc, 4);
      if (!rst) `CHK(ta - tl, 4);
      `CHK(td - ta, 4);
   end
   endtask

   task t_reset;
   begin
      apb(`DWTM_ADDR_STATUS, 1'b0, 32'h0);
      `CHK(q, 32'h0);
      apb(8'h1c, 1'b1, 32'hffffffff);
      `CHK(e, 1'b1);
      $display("Test reset and unmapped done");
   end
   endtask

   task t_control_graphic;
   begin
      memWord <= 16'he800;
      apb(`DWTM_ADDR_CTRL, 1'b1, 32'h01000002);
      run_word(13, 16'h9000, 0);
      apb(`DWTM_ADDR_PC, 1'b0, 32'h0);
      `CHK(q[15:0], 16'h0101);
      apb(`DWTM_ADDR_WORD, 1'b0, 32'h0);
      `CHK(q[15:0], 16'he800);
      `CHK(fetchRequest_r, 1'b1);
      run_word(8, 16'h0123, 0);
      apb(`DWTM_ADDR_STATUS, 1'b0, 32'h0);
      `CHK(q[14:6], 9'h102);
      run_word(2, 16'h8000, 0);
      apb(`DWTM_ADDR_STATUS, 1'b0, 32'h0);
      `CHK(q[14:6], 9'h002);
      `CHK(fetchRequest_r, 1'b0);
      $display("Test control and graphic words done");
   end
   endtask

   task t_restart;
   begin
      slowAnswer <= 1'b0;
      apb(`DWTM_ADDR_CTRL, 1'b1, 32'h4);
      run_word(8, 16'h4142, 0);
      charSecondPending <= 1'b1;
      run_word(0, 16'he000, 0);
      run_word(0, 16'he000, 1);
      charSecondPending <= 1'b0;
      slowAnswer <= 1'b1;
      apb(`DWTM_ADDR_PC, 1'b0, 32'h0);
      `CHK(q[15:0], 16'h0105);
      $display("Test second character restart done");
   end
   endtask

   task t_jump_inhibit;
   begin
      apb(`DWTM_ADDR_CTRL, 1'b1, 32'h4);
      run_word(12, 16'h0400, 0);
      run_word(-1, 16'hf000, 0);
      apb(`DWTM_ADDR_PC, 1'b0, 32'h0);
      `CHK(q[15:0], 16'h0400);
      apb(`DWTM_ADDR_STATUS, 1'b0, 32'h0);
      `CHK(q[14:6], 9'h140);
      if (!fetchRequest_r) apb(`DWTM_ADDR_CTRL, 1'b1, 32'h5);
      if (fetchRequest_r) apb(`DWTM_ADDR_CTRL, 1'b1, 32'h1);
      run_word(14, 16'hc800, 0);
      apb(`DWTM_ADDR_STATUS, 1'b0, 32'h0);
      `CHK(fetchRequest_r, 1'b0);
      $display("Test jump and inhibit done");
   end
   endtask

   task t_spare;
   begin
      apb(`DWTM_ADDR_CTRL, 1'b1, 32'h4);
      run_word(9, 16'he800, 0);
      apb(`DWTM_ADDR_STATUS, 1'b0, 32'h0);
      `CHK(hung_r, 1'b1);
      apb(`DWTM_ADDR_STATUS, 1'b0, 32'h0);
      `CHK(q[16], 1'b1);
      $display("Test spare code done");
   end
   endtask

   // Clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Main sequence
   initial
   begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      slowAnswer = 1'b1;
      charSecondPending = 1'b0;
      memWord = 16'h0000;
      errors = 0;
      testsRun = 0;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      t_reset;
      t_control_graphic;
      t_restart;
      t_jump_inhibit;
      t_spare;
      print_verdict;
   end
endmodule // dwtm_sequencer_tb
